// *** hdl/pcrm_regs.vh ***
`ifndef PCRM_REGS_VH
`define PCRM_REGS_VH
// ****************
// Command codes
// ****************
`define PCRM_CMD_PAGE 8'h00
`define PCRM_CMD_OPMODE 8'h01
`define PCRM_CMD_ONOFF 8'h02
`define PCRM_CMD_CLRFLT 8'h03
`define PCRM_CMD_WGUARD 8'h10
`define PCRM_CMD_STORE 8'h15
`define PCRM_CMD_RESTORE 8'h16
`define PCRM_CMD_PROTO 8'h19
`define PCRM_CMD_FMT 8'h20
`define PCRM_CMD_SETPT 8'h21
`define PCRM_CMD_CEIL 8'h24
`define PCRM_CMD_MHIGH 8'h25
`define PCRM_CMD_MLOW 8'h26
`define PCRM_CMD_VINON 8'h35
`define PCRM_CMD_VINOFF 8'h36
`define PCRM_CMD_RSENSE 8'h38
`define PCRM_CMD_OVF 8'h40
`define PCRM_CMD_OVACT 8'h41
`define PCRM_CMD_OVW 8'h42
`define PCRM_CMD_UVW 8'h43
`define PCRM_CMD_UVF 8'h44
// ****************
// Reset and fixed values
// ****************
`define PCRM_RST_PAGE 8'h00
`define PCRM_RST_OPMODE 8'h00
`define PCRM_RST_ONOFF 8'h1E
`define PCRM_RST_WGUARD 8'h00
`define PCRM_VAL_PROTO 8'hB0
`define PCRM_VAL_FMT 8'h13
`define PCRM_RST_SETPT 16'h2000
`define PCRM_RST_CEIL 16'h8000
`define PCRM_RST_MHIGH 16'h219A
`define PCRM_RST_MLOW 16'h1E66
`define PCRM_RST_VINON 16'hD280
`define PCRM_RST_VINOFF 16'hD240
`define PCRM_RST_RSENSE 16'hBA00
`define PCRM_RST_OVF 16'h2333
`define PCRM_RST_OVACT 8'h80
`define PCRM_RST_OVW 16'h2266
`define PCRM_RST_UVW 16'h1D9A
`define PCRM_RST_UVF 16'h1CCD
// ****************
// Fields and timing
// ****************
`define PCRM_OP_ON_BIT 7
`define PCRM_OP_MARGIN_HI 2'b10
`define PCRM_OP_MARGIN_LO 2'b01
`define PCRM_ONOFF_BUS_BIT 3
`define PCRM_ONOFF_PIN_BIT 2
`define PCRM_ONOFF_POL_BIT 1
`define PCRM_ONOFF_USE_BIT 4
`define PCRM_CLK_MHZ 50
`define PCRM_CLR_TIME_US 500
`define PCRM_CLR_CYCLES (`PCRM_CLR_TIME_US * `PCRM_CLK_MHZ)
`define PCRM_BUSY_TIME_US 500
`define PCRM_BUSY_CYCLES (`PCRM_BUSY_TIME_US * `PCRM_CLK_MHZ)
`endif

// *** hdl/pcrm_top.v ***
`timescale 1ns/1ps
`include "pcrm_regs.vh"
// Functional notes
// - Byte at 0x00, reset 0x00, selects channel for paged commands; not paged.
// - Paged byte 0x01 picks on/off and normal, margin high or low.
// - Paged byte 0x02, default 0x1E, picks pin, bus or both control.
// - Paged send byte 0x03 clears set fault bits of the selected channel and comm_fault.
// - Unpaged byte 0x10, default 0x00, sets write guarding level.
// - Send byte 0x15 stores working memory to nonvolatile storage.
// - Send byte 0x16 reloads sense resistance of all channels from nonvolatile storage.
// - Read byte 0x19 returns fixed 0xB0; read only, not paged.
// - Paged 0x20 reads 0x13; writes unsupported.
// - Paged word 0x21 setpoint, default 0x2000, servo target in normal mode.
// - Paged word 0x24 ceiling, default 0x8000; commanded output never exceeds it.
// - Paged words 0x25/0x26 margin setpoints, defaults 0x219A/0x1E66.
// - Conversion allowed after input exceeds word 0x35, default 0xD280.
// - Input below word 0x36 turns all output enables off.
// - Paged word 0x38 sense resistance, default 0xBA00, scales current readings.
// - Paged word 0x40 overvoltage fault threshold, byte 0x41 action, default 0x80.
// - Paged words 0x42/0x43 warning thresholds raise warnings when crossed, 0x43 only while output is enabled.
// - Paged word 0x44 undervoltage fault threshold, used only for power good.
// - While busy, command bytes are rejected and alert driven low.
// - After clear, commands accepted; flags may stay set up to 500 us.
module pcrm_top #(
	parameter CH = 4,
	parameter CLR_CYCLES = `PCRM_CLR_CYCLES,
	parameter BUSY_CYCLES = `PCRM_BUSY_CYCLES
) (
	// Clock and reset
	input wire clk_sys,
	input wire rstn,
	// Decoded bus transaction
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire cmd_write,
	input wire cmd_send,
	input wire [15:0] cmd_wdata,
	output reg cmd_ack,
	output reg cmd_nack,
	output reg [15:0] cmd_rdata,
	// Nonvolatile memory handshake
	output reg nvm_store,
	output reg nvm_restore,
	input wire nvm_done,
	input wire [15:0] nvm_rsense,
	// Monitor inputs
	input wire control_pin,
	input wire [15:0] vin_meas,
	input wire [CH*16-1:0] vout_meas,
	input wire [CH*16-1:0] iout_raw,
	// Outputs
	output reg [CH-1:0] channel_output_enable,
	output reg [CH*16-1:0] dac_target,
	output reg [CH*32-1:0] iout_scaled,
	output reg [CH-1:0] ov_fault,
	output reg [CH-1:0] ov_warn,
	output reg [CH-1:0] uv_warn,
	output reg [CH-1:0] power_good,
	output reg comm_fault,
	output reg alert_out_n,
	output reg [7:0] write_guard_level
);
	// ****************
	// Helpers
	// ****************
	function is_paged;
		input [7:0] c;
		begin
			case (c)
				`PCRM_CMD_OPMODE, `PCRM_CMD_ONOFF, `PCRM_CMD_CLRFLT, `PCRM_CMD_FMT,
				`PCRM_CMD_SETPT, `PCRM_CMD_CEIL, `PCRM_CMD_MHIGH, `PCRM_CMD_MLOW,
				`PCRM_CMD_RSENSE, `PCRM_CMD_OVF, `PCRM_CMD_OVACT, `PCRM_CMD_OVW,
				`PCRM_CMD_UVW, `PCRM_CMD_UVF: is_paged = 1'b1;
				default: is_paged = 1'b0;
			endcase
		end
	endfunction
	function is_writable;
		input [7:0] c;
		begin
			case (c)
				`PCRM_CMD_PAGE, `PCRM_CMD_OPMODE, `PCRM_CMD_ONOFF, `PCRM_CMD_WGUARD,
				`PCRM_CMD_SETPT, `PCRM_CMD_CEIL, `PCRM_CMD_MHIGH, `PCRM_CMD_MLOW,
				`PCRM_CMD_VINON, `PCRM_CMD_VINOFF, `PCRM_CMD_RSENSE, `PCRM_CMD_OVF,
				`PCRM_CMD_OVACT, `PCRM_CMD_OVW, `PCRM_CMD_UVW, `PCRM_CMD_UVF: is_writable = 1'b1;
				default: is_writable = 1'b0;
			endcase
		end
	endfunction
	// Level exceeds compare of 16-bit linear words (5-bit exp, 11-bit mantissa)
	function signed [47:0] lin11;
		input [15:0] w;
		reg signed [4:0] e;
		reg signed [10:0] m;
		begin
			e = w[15:11];
			m = w[10:0];
			lin11 = (e >= 0) ? ($signed({{37{m[10]}}, m}) <<< (e + 16)) :
				($signed({{37{m[10]}}, m}) <<< 16) >>> (-e);
		end
	endfunction

	// ****************
	// Storage
	// ****************
	reg [7:0] page_select;
	reg [7:0] operating_mode_ctrl [0:CH-1];
	reg [7:0] on_off_source_cfg [0:CH-1];
	reg [15:0] output_setpoint [0:CH-1];
	reg [15:0] output_ceiling [0:CH-1];
	reg [15:0] margin_high_setpoint [0:CH-1];
	reg [15:0] margin_low_setpoint [0:CH-1];
	reg [15:0] sense_resistance [0:CH-1];
	reg [15:0] out_ov_fault_threshold [0:CH-1];
	reg [7:0] out_ov_fault_action [0:CH-1];
	reg [15:0] out_ov_warn_threshold [0:CH-1];
	reg [15:0] out_uv_warn_threshold [0:CH-1];
	reg [15:0] out_uv_fault_threshold [0:CH-1];
	reg [15:0] input_turn_on_level;
	reg [15:0] input_turn_off_level;
	reg [31:0] busy_cnt_reg;
	reg busy_rs_reg;
	reg restore_pend_reg;
	reg [31:0] clr_cnt_reg;
	reg [CH-1:0] clr_pend_reg;
	reg conv_ok_reg;
	reg [2:0] pin_sync_reg;
	reg pin_level_reg;

	wire [1:0] pg = page_select[1:0];
	wire busy = (busy_cnt_reg != 32'h0) || busy_rs_reg;
	wire take = cmd_valid && !busy;
	wire paged_ok = !is_paged(cmd_code) || (page_select < CH);
	wire known = is_writable(cmd_code) || cmd_code == `PCRM_CMD_PROTO ||
		cmd_code == `PCRM_CMD_FMT || cmd_code == `PCRM_CMD_CLRFLT ||
		cmd_code == `PCRM_CMD_STORE || cmd_code == `PCRM_CMD_RESTORE;
	wire is_sendcmd = cmd_code == `PCRM_CMD_CLRFLT || cmd_code == `PCRM_CMD_STORE ||
		cmd_code == `PCRM_CMD_RESTORE;
	// Guard level: 0x80 all locked except 0x10, 0x40 page/mode only, 0x20 adds on/off cfg
	wire guarded = (write_guard_level[7] && cmd_code != `PCRM_CMD_WGUARD) ||
		(write_guard_level[6] && !(cmd_code == `PCRM_CMD_WGUARD ||
		cmd_code == `PCRM_CMD_PAGE || cmd_code == `PCRM_CMD_OPMODE)) ||
		(write_guard_level[5] && !(cmd_code == `PCRM_CMD_WGUARD ||
		cmd_code == `PCRM_CMD_PAGE || cmd_code == `PCRM_CMD_OPMODE ||
		cmd_code == `PCRM_CMD_ONOFF));
	wire wr_ok = take && cmd_write && is_writable(cmd_code) && paged_ok && !guarded;
	wire send_ok = take && cmd_send && is_sendcmd && paged_ok;
	wire bad = take && ((cmd_write && !(is_writable(cmd_code) && paged_ok && !guarded)) ||
		(cmd_send && !(is_sendcmd && paged_ok)) || (!cmd_write && !cmd_send &&
		(!known || is_sendcmd || !paged_ok)));

	// ****************
	// Bus answers
	// ****************
	reg [15:0] rd_next;
	always @* begin
		case (cmd_code)
			`PCRM_CMD_PAGE: rd_next = {8'h00, page_select};
			`PCRM_CMD_OPMODE: rd_next = {8'h00, operating_mode_ctrl[pg]};
			`PCRM_CMD_ONOFF: rd_next = {8'h00, on_off_source_cfg[pg]};
			`PCRM_CMD_WGUARD: rd_next = {8'h00, write_guard_level};
			`PCRM_CMD_PROTO: rd_next = {8'h00, `PCRM_VAL_PROTO};
			`PCRM_CMD_FMT: rd_next = {8'h00, `PCRM_VAL_FMT};
			`PCRM_CMD_SETPT: rd_next = output_setpoint[pg];
			`PCRM_CMD_CEIL: rd_next = output_ceiling[pg];
			`PCRM_CMD_MHIGH: rd_next = margin_high_setpoint[pg];
			`PCRM_CMD_MLOW: rd_next = margin_low_setpoint[pg];
			`PCRM_CMD_VINON: rd_next = input_turn_on_level;
			`PCRM_CMD_VINOFF: rd_next = input_turn_off_level;
			`PCRM_CMD_RSENSE: rd_next = sense_resistance[pg];
			`PCRM_CMD_OVF: rd_next = out_ov_fault_threshold[pg];
			`PCRM_CMD_OVACT: rd_next = {8'h00, out_ov_fault_action[pg]};
			`PCRM_CMD_OVW: rd_next = out_ov_warn_threshold[pg];
			`PCRM_CMD_UVW: rd_next = out_uv_warn_threshold[pg];
			`PCRM_CMD_UVF: rd_next = out_uv_fault_threshold[pg];
			default: rd_next = 16'h0000;
		endcase
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cmd_ack <= 1'b0;
			cmd_nack <= 1'b0;
			cmd_rdata <= 16'h0000;
			comm_fault <= 1'b0;
			alert_out_n <= 1'b1;
			page_select <= `PCRM_RST_PAGE;
			write_guard_level <= `PCRM_RST_WGUARD;
			input_turn_on_level <= `PCRM_RST_VINON;
			input_turn_off_level <= `PCRM_RST_VINOFF;
			busy_cnt_reg <= 32'h0;
			busy_rs_reg <= 1'b0;
			restore_pend_reg <= 1'b0;
			nvm_store <= 1'b0;
			nvm_restore <= 1'b0;
			clr_cnt_reg <= 32'h0;
		end else begin
			cmd_ack <= take && !bad;
			cmd_nack <= (cmd_valid && busy) || bad;
			nvm_store <= send_ok && cmd_code == `PCRM_CMD_STORE;
			nvm_restore <= send_ok && cmd_code == `PCRM_CMD_RESTORE;
			if (take && !cmd_write && !cmd_send)
				cmd_rdata <= rd_next;
			// Busy: settle time after sense write, or until memory copy done
			if (wr_ok && cmd_code == `PCRM_CMD_RSENSE)
				busy_cnt_reg <= BUSY_CYCLES;
			else if (busy_cnt_reg != 32'h0)
				busy_cnt_reg <= busy_cnt_reg - 32'h1;
			if (send_ok && (cmd_code == `PCRM_CMD_STORE || cmd_code == `PCRM_CMD_RESTORE))
				busy_rs_reg <= 1'b1;
			else if (nvm_done)
				busy_rs_reg <= 1'b0;
			// Only a restore may reload the working copy
			if (send_ok && cmd_code == `PCRM_CMD_RESTORE)
				restore_pend_reg <= 1'b1;
			else if (nvm_done)
				restore_pend_reg <= 1'b0;
			// Alert low on busy refusal or bad access; cleared by fault clear
			if ((cmd_valid && busy) || bad)
				alert_out_n <= 1'b0;
			else if (send_ok && cmd_code == `PCRM_CMD_CLRFLT)
				alert_out_n <= 1'b1;
			if (bad)
				comm_fault <= 1'b1;
			else if (clr_cnt_reg == 32'h1)
				comm_fault <= 1'b0;
			// Clear completes after the settle delay
			if (send_ok && cmd_code == `PCRM_CMD_CLRFLT)
				clr_cnt_reg <= CLR_CYCLES;
			else if (clr_cnt_reg != 32'h0)
				clr_cnt_reg <= clr_cnt_reg - 32'h1;
			if (wr_ok) begin
				case (cmd_code)
					`PCRM_CMD_PAGE: page_select <= cmd_wdata[7:0];
					`PCRM_CMD_WGUARD: write_guard_level <= cmd_wdata[7:0];
					`PCRM_CMD_VINON: input_turn_on_level <= cmd_wdata;
					`PCRM_CMD_VINOFF: input_turn_off_level <= cmd_wdata;
					default: ;
				endcase
			end
		end
	end

	// ****************
	// Control pin sync and input window
	// ****************
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_sync_reg <= 3'b000;
			pin_level_reg <= 1'b0;
			conv_ok_reg <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], control_pin};
			if (pin_sync_reg[1] == pin_sync_reg[2])
				pin_level_reg <= pin_sync_reg[2];
			if (lin11(vin_meas) > lin11(input_turn_on_level))
				conv_ok_reg <= 1'b1;
			else if (lin11(vin_meas) < lin11(input_turn_off_level))
				conv_ok_reg <= 1'b0;
		end
	end

	// ****************
	// Per-channel bank
	// ****************
	genvar i;
	generate
		for (i = 0; i < CH; i = i + 1) begin : g_ch
			wire sel = (pg == i);
			wire [15:0] vm = vout_meas[i*16 +: 16];
			wire [7:0] op = operating_mode_ctrl[i];
			wire [7:0] oc = on_off_source_cfg[i];
			wire pin_on = pin_level_reg ^ !oc[`PCRM_ONOFF_POL_BIT];
			wire bus_on = op[`PCRM_OP_ON_BIT];
			wire want = !oc[`PCRM_ONOFF_USE_BIT] ? 1'b1 :
				((!oc[`PCRM_ONOFF_BUS_BIT] || bus_on) &&
				(!oc[`PCRM_ONOFF_PIN_BIT] || pin_on));
			wire [15:0] tgt = (op[5:4] == `PCRM_OP_MARGIN_HI) ? margin_high_setpoint[i] :
				(op[5:4] == `PCRM_OP_MARGIN_LO) ? margin_low_setpoint[i] :
				output_setpoint[i];
			wire [31:0] prod = iout_raw[i*16 +: 16] * sense_resistance[i];
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					operating_mode_ctrl[i] <= `PCRM_RST_OPMODE;
					on_off_source_cfg[i] <= `PCRM_RST_ONOFF;
					output_setpoint[i] <= `PCRM_RST_SETPT;
					output_ceiling[i] <= `PCRM_RST_CEIL;
					margin_high_setpoint[i] <= `PCRM_RST_MHIGH;
					margin_low_setpoint[i] <= `PCRM_RST_MLOW;
					sense_resistance[i] <= `PCRM_RST_RSENSE;
					out_ov_fault_threshold[i] <= `PCRM_RST_OVF;
					out_ov_fault_action[i] <= `PCRM_RST_OVACT;
					out_ov_warn_threshold[i] <= `PCRM_RST_OVW;
					out_uv_warn_threshold[i] <= `PCRM_RST_UVW;
					out_uv_fault_threshold[i] <= `PCRM_RST_UVF;
					clr_pend_reg[i] <= 1'b0;
					channel_output_enable[i] <= 1'b0;
					dac_target[i*16 +: 16] <= 16'h0000;
					iout_scaled[i*32 +: 32] <= 32'h0;
					ov_fault[i] <= 1'b0;
					ov_warn[i] <= 1'b0;
					uv_warn[i] <= 1'b0;
					power_good[i] <= 1'b0;
				end else begin
					if (wr_ok && sel) begin
						case (cmd_code)
							`PCRM_CMD_OPMODE: operating_mode_ctrl[i] <= cmd_wdata[7:0];
							`PCRM_CMD_ONOFF: on_off_source_cfg[i] <= cmd_wdata[7:0];
							`PCRM_CMD_SETPT: output_setpoint[i] <= cmd_wdata;
							`PCRM_CMD_CEIL: output_ceiling[i] <= cmd_wdata;
							`PCRM_CMD_MHIGH: margin_high_setpoint[i] <= cmd_wdata;
							`PCRM_CMD_MLOW: margin_low_setpoint[i] <= cmd_wdata;
							`PCRM_CMD_RSENSE: sense_resistance[i] <= cmd_wdata;
							`PCRM_CMD_OVF: out_ov_fault_threshold[i] <= cmd_wdata;
							`PCRM_CMD_OVACT: out_ov_fault_action[i] <= cmd_wdata[7:0];
							`PCRM_CMD_OVW: out_ov_warn_threshold[i] <= cmd_wdata;
							`PCRM_CMD_UVW: out_uv_warn_threshold[i] <= cmd_wdata;
							`PCRM_CMD_UVF: out_uv_fault_threshold[i] <= cmd_wdata;
							default: ;
						endcase
					end else if (nvm_done && restore_pend_reg) begin
						sense_resistance[i] <= nvm_rsense;
					end
					if (send_ok && cmd_code == `PCRM_CMD_CLRFLT && sel)
						clr_pend_reg[i] <= 1'b1;
					else if (clr_cnt_reg == 32'h1)
						clr_pend_reg[i] <= 1'b0;
					channel_output_enable[i] <= want && conv_ok_reg && !ov_fault[i];
					dac_target[i*16 +: 16] <= (tgt > output_ceiling[i]) ?
						output_ceiling[i] : tgt;
					iout_scaled[i*32 +: 32] <= prod;
					// Set wins over the delayed clear
					if (vm > out_ov_fault_threshold[i])
						ov_fault[i] <= out_ov_fault_action[i][7];
					else if (clr_pend_reg[i] && clr_cnt_reg == 32'h1)
						ov_fault[i] <= 1'b0;
					if (vm > out_ov_warn_threshold[i])
						ov_warn[i] <= 1'b1;
					else if (clr_pend_reg[i] && clr_cnt_reg == 32'h1)
						ov_warn[i] <= 1'b0;
					if (vm < out_uv_warn_threshold[i] && channel_output_enable[i])
						uv_warn[i] <= 1'b1;
					else if (clr_pend_reg[i] && clr_cnt_reg == 32'h1)
						uv_warn[i] <= 1'b0;
					power_good[i] <= channel_output_enable[i] &&
						(vm > out_uv_fault_threshold[i]);
				end
			end
		end
	endgenerate
endmodule // pcrm_top

// *** sim/pcrm_chk.sv ***
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module pcrm_chk (
	// Clock and reset
	input wire clk_sys,
	input wire rstn,
	// Transaction
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire cmd_write,
	input wire cmd_send,
	input wire [15:0] cmd_wdata,
	input wire cmd_ack,
	input wire cmd_nack,
	input wire [15:0] cmd_rdata,
	// Status
	input wire nvm_store,
	input wire nvm_restore,
	input wire comm_fault,
	input wire alert_out_n,
	input wire [7:0] write_guard_level
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	a_one_answer: assert property (cmd_valid |=> cmd_ack != cmd_nack)
		else $error("request without exactly one answer");
	a_no_stray: assert property (!cmd_valid |=> !cmd_ack && !cmd_nack)
		else $error("answer without request");
	a_store_pulse: assert property (nvm_store |-> cmd_ack && $past(cmd_send) && $past(cmd_code) == 8'h15)
		else $error("store pulse without accepted store");
	a_restore_pulse: assert property (nvm_restore |-> cmd_ack && $past(cmd_send) && $past(cmd_code) == 8'h16)
		else $error("restore pulse without accepted restore");
	a_nack_alert: assert property (cmd_nack |-> ##[0:1] !alert_out_n)
		else $error("refusal without alert");
	a_ro_write: assert property (cmd_valid && cmd_write && (cmd_code == 8'h19 || cmd_code == 8'h20) |=> cmd_nack ##[0:1] comm_fault)
		else $error("write to read-only place not refused");
	a_proto_read: assert property (cmd_valid && !cmd_write && !cmd_send && cmd_code == 8'h19 |=> !cmd_ack || cmd_rdata == 16'h00B0)
		else $error("protocol summary wrong");
	a_format_read: assert property (cmd_valid && !cmd_write && !cmd_send && cmd_code == 8'h20 |=> !cmd_ack || cmd_rdata == 16'h0013)
		else $error("format byte wrong");
	a_busy_refuse: assert property (cmd_valid && cmd_ack && $past(cmd_valid) && $past(cmd_write) && $past(cmd_code) == 8'h38 |=> cmd_nack)
		else $error("request taken while busy");
	a_guard_copy: assert property (cmd_valid && cmd_write && cmd_code == 8'h10 ##1 cmd_ack |=> write_guard_level == $past(cmd_wdata[7:0], 2))
		else $error("guard level not updated");
endmodule // pcrm_chk
bind pcrm_top pcrm_chk i_pcrm_chk (.clk_sys, .rstn, .cmd_valid, .cmd_code, .cmd_write, .cmd_send,
	.cmd_wdata, .cmd_ack, .cmd_nack, .cmd_rdata, .nvm_store, .nvm_restore, .comm_fault,
	.alert_out_n, .write_guard_level);

// *** sim/pcrm_nvm_model.sv ***
`timescale 1ns/1ps
// ****************
// Memory model
// ****************
module pcrm_nvm_model #(
	parameter DLY = 6,
	parameter [15:0] IMG = 16'h1234
) (
	// Clock and reset
	input wire clk_sys,
	input wire rstn,
	// Handshake
	input wire nvm_store,
	input wire nvm_restore,
	output reg nvm_done,
	output wire [15:0] nvm_rsense
);
	integer cnt_reg;
	assign nvm_rsense = IMG;
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 0;
			nvm_done <= 1'b0;
		end else begin
			nvm_done <= (cnt_reg == 1);
			if (nvm_store || nvm_restore)
				cnt_reg <= DLY;
			else if (cnt_reg != 0)
				cnt_reg <= cnt_reg - 1;
		end
	end
endmodule // pcrm_nvm_model

// *** sim/test_pmbus_command_register_map.sv ***
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module test_pmbus_command_register_map;
	reg clk_sys = 0, rstn = 0, cmd_valid = 0, cmd_write = 0, cmd_send = 0, control_pin = 0;
	reg [7:0] cmd_code = 8'h00;
	reg [15:0] cmd_wdata = 16'h0000, vin_meas = 16'h0000;
	reg [63:0] vout_meas = {4{16'h2000}}, iout_raw = 64'h0;
	reg [31:0] rnd = 32'h92DC002F;
	wire cmd_ack, cmd_nack, nvm_store, nvm_restore, nvm_done, comm_fault, alert_out_n;
	wire [15:0] cmd_rdata, nvm_rsense;
	wire [3:0] channel_output_enable, ov_fault, ov_warn, uv_warn, power_good;
	wire [63:0] dac_target;
	wire [127:0] iout_scaled;
	wire [7:0] write_guard_level;
	integer fails = 0, checks_done = 0, i;
	reg [15:0] ex [4];
	reg [7:0] dc [18] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'h24, 8'h25,
		8'h26, 8'h35, 8'h36, 8'h38, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
	reg [15:0] dv [18] = '{16'h0000, 16'h0000, 16'h001E, 16'h0000, 16'h00B0, 16'h0013,
		16'h2000, 16'h8000, 16'h219A, 16'h1E66, 16'hD280, 16'hD240, 16'hBA00, 16'h2333,
		16'h0080, 16'h2266, 16'h1D9A, 16'h1CCD};
	pcrm_top #(.CLR_CYCLES(8), .BUSY_CYCLES(8)) i_pcrm_top (.clk_sys, .rstn, .cmd_valid,
		.cmd_code, .cmd_write, .cmd_send, .cmd_wdata, .cmd_ack, .cmd_nack, .cmd_rdata,
		.nvm_store, .nvm_restore, .nvm_done, .nvm_rsense, .control_pin, .vin_meas,
		.vout_meas, .iout_raw, .channel_output_enable, .dac_target, .iout_scaled, .ov_fault,
		.ov_warn, .uv_warn, .power_good, .comm_fault, .alert_out_n, .write_guard_level);
	pcrm_nvm_model i_pcrm_nvm_model (.clk_sys, .rstn, .nvm_store, .nvm_restore, .nvm_done,
		.nvm_rsense);
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task cmd(input [7:0] c, input w, input s, input [15:0] d, input ea);
		@(negedge clk_sys);
		{cmd_valid, cmd_code, cmd_write, cmd_send, cmd_wdata} = {1'b1, c, w, s, d};
		@(negedge clk_sys);
		cmd_valid = 0;
		chk($sformatf("answer %h", c), {ea, !ea}, {cmd_ack, cmd_nack});
	endtask
	task rd(input [7:0] c, input [15:0] e);
		cmd(c, 0, 0, 0, 1);
		chk($sformatf("read %h", c), e, cmd_rdata);
	endtask
	task wr(input [7:0] c, input [15:0] d);
		cmd(c, 1, 0, d, 1);
	endtask
	task waitn(input integer n);
		repeat (n) @(negedge clk_sys);
	endtask
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		final_report;
	end
	initial begin
		repeat (12) @(negedge clk_sys);
		rstn = 1;
		chk("alert idle", 1, alert_out_n);
		for (i = 0; i < 18; i++) rd(dc[i], dv[i]);
		$display("test defaults done");
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			ex[i] = rnd[15:0];
			wr(8'h00, i[15:0]);
			wr(8'h21, ex[i]);
		end
		for (i = 0; i < 4; i++) begin
			wr(8'h00, i[15:0]);
			rd(8'h21, ex[i]);
		end
		rd(8'h00, 16'h0003);
		wr(8'h00, 16'h0000);
		$display("test paging done");
		wr(8'h21, 16'h9000);
		waitn(2);
		chk("clipped target", 16'h8000, dac_target[15:0]);
		wr(8'h24, 16'hA000);
		waitn(2);
		chk("normal target", 16'h9000, dac_target[15:0]);
		wr(8'h01, 16'h0020);
		waitn(2);
		chk("margin high", 16'h219A, dac_target[15:0]);
		wr(8'h01, 16'h0010);
		waitn(2);
		chk("margin low", 16'h1E66, dac_target[15:0]);
		wr(8'h01, 16'h0080);
		wr(8'h21, 16'h2000);
		$display("test setpoints done");
		control_pin = 1;
		vin_meas = 16'hD2C0;
		for (i = 0; i < 200 && channel_output_enable[0] !== 1'b1; i++) @(negedge clk_sys);
		chk("enable on", 1, channel_output_enable[0]);
		waitn(1);
		chk("power good", 1, power_good[0]);
		vin_meas = 16'hD200;
		for (i = 0; i < 200 && channel_output_enable !== 4'h0; i++) @(negedge clk_sys);
		chk("enable off", 0, channel_output_enable);
		vin_meas = 16'hD2C0;
		vout_meas[15:0] = 16'h2300;
		waitn(8);
		chk("ov warn only", 2'b10, {ov_warn[0], ov_fault[0]});
		vout_meas[15:0] = 16'h1D00;
		waitn(8);
		chk("uv warn", 1, uv_warn[0]);
		vout_meas[15:0] = 16'h2400;
		waitn(8);
		chk("ov fault", 1, ov_fault[0]);
		vout_meas[15:0] = 16'h2000;
		$display("test supervision done");
		cmd(8'h19, 1, 0, 16'h00FF, 0);
		cmd(8'h20, 1, 0, 16'h00FF, 0);
		cmd(8'h7F, 1, 0, 16'h0000, 0);
		chk("fault and alert", 2'b10, {comm_fault, alert_out_n});
		rd(8'h19, 16'h00B0);
		wr(8'h10, 16'h0080);
		waitn(1);
		chk("guard level", 8'h80, write_guard_level);
		cmd(8'h21, 1, 0, 16'h1111, 0);
		wr(8'h10, 16'h0000);
		rd(8'h21, 16'h2000);
		$display("test refusals done");
		rnd = lfsr(rnd);
		iout_raw = {4{8'h00, rnd[23:16]}};
		@(negedge clk_sys);
		{cmd_valid, cmd_code, cmd_write, cmd_wdata} = {1'b1, 8'h38, 1'b1, rnd[15:0]};
		@(negedge clk_sys);
		chk("sense write", 1, cmd_ack);
		{cmd_code, cmd_write} = {8'h21, 1'b0};
		@(negedge clk_sys);
		cmd_valid = 0;
		chk("busy refusal", 2'b10, {cmd_nack, alert_out_n});
		waitn(12);
		rd(8'h38, rnd[15:0]);
		chk("scaled current", rnd[23:16] * rnd[15:0], iout_scaled[31:0]);
		cmd(8'h15, 0, 1, 16'h0000, 1);
		cmd(8'h21, 0, 0, 16'h0000, 0);
		for (i = 0; i < 50 && nvm_done !== 1'b1; i++) @(negedge clk_sys);
		waitn(2);
		rd(8'h38, rnd[15:0]);
		cmd(8'h16, 0, 1, 16'h0000, 1);
		for (i = 0; i < 50 && nvm_done !== 1'b1; i++) @(negedge clk_sys);
		waitn(2);
		rd(8'h38, 16'h1234);
		$display("test busy and memory done");
		cmd(8'h03, 0, 1, 16'h0000, 1);
		rd(8'h19, 16'h00B0);
		chk("alert released", 1, alert_out_n);
		waitn(12);
		chk("flags cleared", 0, {comm_fault, ov_fault[0], ov_warn[0], uv_warn[0]});
		$display("test clearing done");
		final_report;
	end
endmodule // test_pmbus_command_register_map
